/* src/flsc_pkg.sv */
package flsc_pkg;

  // ==============================
  // Register map of the plain register port.
  // ==============================
  localparam logic [3:0] FLSC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] FLSC_ADDR_STATUS = 4'h4;
  localparam logic [3:0] FLSC_ADDR_FAULTS = 4'h8;

  // Control register field positions.
  localparam int FLSC_CTRL_DEEP_SLEEP_SELECT = 0;
  localparam int FLSC_CTRL_POWER_DOWN_SELECT = 1;
  localparam int FLSC_CTRL_SLEEP_AFTER_HANDLER = 2;
  localparam int FLSC_CTRL_EVENT_ON_PENDING_IRQ = 3;
  localparam int FLSC_CTRL_GLOBAL_IRQ_MASK_BIT = 4;

  // Control register value after reset.
  localparam logic [4:0] FLSC_CTRL_RESET = 5'h00;

  // Number of fault sources gathered by the classifier.
  localparam int FLSC_NUM_FAULTS = 10;

  // Fault source bit positions.
  localparam int FLSC_F_SVC_PRIO = 0;
  localparam int FLSC_F_BREAKPOINT_INSTR = 1;
  localparam int FLSC_F_LDST_BUS = 2;
  localparam int FLSC_F_NEVER_EXEC = 3;
  localparam int FLSC_F_FETCH_BUS = 4;
  localparam int FLSC_F_VECTOR_BUS = 5;
  localparam int FLSC_F_UNDEF = 6;
  localparam int FLSC_F_ISTATE = 7;
  localparam int FLSC_F_UNALIGNED = 8;
  localparam int FLSC_F_PROTECTION = 9;

  // Run states of the core.
  typedef enum logic [2:0] {
    FLSC_RUN,
    FLSC_SLEEP_IRQ,
    FLSC_SLEEP_EVENT,
    FLSC_LOCKUP_NMI,
    FLSC_LOCKUP_HARD
  } flsc_state_t;

endpackage : flsc_pkg

/* src/flsc_fault_if.sv */
`timescale 1ns/100ps
// ==============================
// Fault sources, qualified sources and the any-fault request between classifier and top.
// ==============================
interface flsc_fault_if;
  import flsc_pkg::*;
  logic [FLSC_NUM_FAULTS-1:0] src;
  logic anyFault;
  logic [FLSC_NUM_FAULTS-1:0] seen;
  modport classifier(input src, output anyFault, output seen);
  modport top(output src, input anyFault, input seen);
endinterface : flsc_fault_if

/* src/flsc_fault_classifier.sv */
`timescale 1ns/100ps
// ==============================
// Fault classifier: merges every fault source into one fault request.
// ==============================
module flsc_fault_classifier
  import flsc_pkg::*;
(
  flsc_fault_if.classifier fault // Fault source bundle.
);

  // Per-source qualification, one term a source.
  genvar i;
  generate
    for (i = 0; i < FLSC_NUM_FAULTS; i++) begin : gSrc
      assign fault.seen[i] = fault.src[i];
    end
  endgenerate

  // Any qualified source becomes one fault request.
  assign fault.anyFault = |fault.seen;

endmodule : flsc_fault_classifier

/* src/flsc_fault_lockup_sleep_control.sv */
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
// Summary of operation
// - Any fault takes hard fault or locks up.
// - Supervisor call at blocking priority is fault.
// - Breakpoint without debugger is a fault.
// - Load, store, vector bus errors are faults.
// - Fetch from never-executable or erroring location faults.
// - Undefined instruction or cleared state bit faults.
// - Unaligned access or protection violation faults.
// - Hard fault preempts all but reset, NMI.
// - Fault in NMI/hard handler or unstack error locks.
// - No fetch or execute while locked.
// - Lockup left by reset, halt, NMI-from-hard.
// - NMI never releases lockup born in NMI.
// - Deep-sleep select picks sleep or deep sleep.
// - Power-down select picks stop or standby.
// - Wait-for-interrupt sleeps unconditionally.
// - Wait-for-event consumes set event or sleeps.
// - External or sent event sets event bit.
// - Sleep-after-handler sleeps on return to thread.
// - Interrupt sleep wakes on sufficient exception, NMI or debug halt only.
// - Masked interrupt wakes but handler waits.
// - Event sleep wakes on exception or event.
// - Event-on-pending makes new pending irq wake.
// - Sufficient means above current priority level.
module flsc_fault_lockup_sleep_control
  import flsc_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic [3:0] regAddr, // Register address.
  input wire logic [31:0] regWdata, // Register write data.
  input wire logic regWr, // Register write strobe.
  input wire logic regRd, // Register read strobe.
  input wire logic [1:0] currentPrio, // Current priority.
  input wire logic [1:0] svcPrio, // Supervisor-call priority.
  input wire logic svcExec, // Supervisor call executed.
  input wire logic bkptExec, // Breakpoint executed.
  input wire logic debugAttached, // Debugger attached.
  input wire logic ldstBusErr, // Load or store bus error.
  input wire logic vectorBusErr, // Vector fetch bus error.
  input wire logic neverExecFetch, // Never-executable fetch.
  input wire logic fetchBusErr, // Fetch bus error.
  input wire logic undefExec, // Undefined instruction.
  input wire logic instrStateClear, // Instruction-state bit clear.
  input wire logic unalignedAccess, // Unaligned load or store.
  input wire logic protectionFault, // Protection violation.
  input wire logic inNmiHandler, // In NMI handler.
  input wire logic inHardFaultHandler, // In hard-fault handler.
  input wire logic unstackPsrBusErr, // Unstack bus error, main stack.
  input wire logic debugHalt, // Debugger halt request.
  input wire logic nmiReq, // NMI request.
  input wire logic excPending, // Pending exception, enabled.
  input wire logic [1:0] excPrio, // Its priority.
  input wire logic irqNewPending, // New pending interrupt.
  input wire logic eventIn, // External event input pin.
  input wire logic sentEvent, // Send-event from another processor.
  input wire logic waitIrqInstr, // Wait-for-interrupt executed.
  input wire logic waitEventInstr, // Wait-for-event executed.
  input wire logic excReturnThread, // Return to thread.
  output logic [31:0] regRdata, // Register read data.
  output logic hardFaultReq, // Take the hard-fault exception.
  output logic lockup, // Core is locked up.
  output logic fetchEnable, // Core may fetch and execute.
  output logic sleeping, // Core is sleeping.
  output logic deepSleep, // Core is in deep sleep.
  output logic standbyReq, // Deep sleep requests standby, else stop.
  output logic excTakeAllowed // Handler may start.
);

  // ==============================
  // Reset synchroniser and pin synchroniser.
  // ==============================
  logic rstMeta;
  logic rstSync;
  logic evMeta;
  logic evSync;

  // Releases the reset through two flip-flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Brings the external event pin into the clock domain.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      evMeta <= 1'b0;
      evSync <= 1'b0;
    end else begin
      evMeta <= eventIn;
      evSync <= evMeta;
    end
  end

  // ==============================
  // Registers.
  // ==============================
  logic [4:0] ctrl;
  logic [FLSC_NUM_FAULTS-1:0] faultSticky;
  flsc_state_t state;
  flsc_state_t next_state;
  logic eventBit;
  logic lastFaultLock;

  // Control register: written by software.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      ctrl <= FLSC_CTRL_RESET;
    end else if (regWr && regAddr == FLSC_ADDR_CTRL) begin
      ctrl <= regWdata[4:0];
    end
  end

  // ==============================
  // Fault gathering.
  // ==============================
  flsc_fault_if faultBus ();

  flsc_fault_classifier uClassifier (
    .fault(faultBus.classifier)
  );

  // supervisor-call priority fault; lower value is higher priority.
  assign faultBus.src[FLSC_F_SVC_PRIO] = svcExec && (currentPrio <= svcPrio);
  assign faultBus.src[FLSC_F_BREAKPOINT_INSTR] = bkptExec && !debugAttached;
  assign faultBus.src[FLSC_F_LDST_BUS] = ldstBusErr;
  assign faultBus.src[FLSC_F_VECTOR_BUS] = vectorBusErr;
  assign faultBus.src[FLSC_F_NEVER_EXEC] = neverExecFetch;
  assign faultBus.src[FLSC_F_FETCH_BUS] = fetchBusErr;
  // undefined instruction and cleared state bit.
  assign faultBus.src[FLSC_F_UNDEF] = undefExec;
  assign faultBus.src[FLSC_F_ISTATE] = instrStateClear;
  assign faultBus.src[FLSC_F_UNALIGNED] = unalignedAccess;
  assign faultBus.src[FLSC_F_PROTECTION] = protectionFault;

  // Fault seen only while the core runs instructions.
  logic running;
  logic inPriorityHandler;
  logic faultNow;
  logic lockEnter;
  assign running = (state == FLSC_RUN);
  assign inPriorityHandler = inNmiHandler || inHardFaultHandler;
  assign faultNow = running && faultBus.anyFault;
  // lockup on fault in NMI or hard handler, or unstack error.
  assign lockEnter = (faultNow && inPriorityHandler) || (running && unstackPsrBusErr);

  // Sticky record of fault sources; a new fault wins over the clear.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      faultSticky <= '0;
    end else begin
      faultSticky <= ((regWr && regAddr == FLSC_ADDR_FAULTS) ?
                      (faultSticky & ~regWdata[FLSC_NUM_FAULTS-1:0]) : faultSticky)
                     | (running ? faultBus.seen : '0);
    end
  end

  // fault raises hard fault unless it locks up.
  // hard fault preempts all but reset and NMI.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      hardFaultReq <= 1'b0;
    end else begin
      hardFaultReq <= faultNow && !inPriorityHandler && !unstackPsrBusErr;
    end
  end

  // ==============================
  // Wakeup judgement.
  // ==============================
  logic sufficient;
  logic eventArrive;
  logic wakeIrq;
  logic wakeEvent;

  // sufficient priority beats the current level.
  assign sufficient = excPending && (excPrio < currentPrio);
  // new pending interrupt acts as event when enabled.
  assign eventArrive = evSync || sentEvent ||
                       (ctrl[FLSC_CTRL_EVENT_ON_PENDING_IRQ] && irqNewPending);
  // interrupt sleep wakes on sufficient exception.
  // masked interrupt still wakes the core.
  assign wakeIrq = sufficient || nmiReq;
  // event sleep wakes on exception or event.
  assign wakeEvent = wakeIrq || eventArrive;

  // ==============================
  // Run-state machine.
  // ==============================
  always_comb begin
    next_state = state;
    case (state)
      FLSC_RUN: begin
        if (lockEnter) begin
          next_state = inNmiHandler ? FLSC_LOCKUP_NMI : FLSC_LOCKUP_HARD;
        end else if (faultNow) begin
          next_state = FLSC_RUN;
        end else if (waitIrqInstr) begin
          next_state = FLSC_SLEEP_IRQ;
        end else if (waitEventInstr && !eventBit && !eventArrive) begin
          // sleep only with event bit clear.
          next_state = FLSC_SLEEP_EVENT;
        end else if (excReturnThread && ctrl[FLSC_CTRL_SLEEP_AFTER_HANDLER]) begin
          next_state = FLSC_SLEEP_IRQ;
        end
      end
      FLSC_SLEEP_IRQ: begin
        if (wakeIrq || debugHalt) begin
          next_state = FLSC_RUN;
        end
      end
      FLSC_SLEEP_EVENT: begin
        if (wakeEvent || debugHalt) begin
          next_state = FLSC_RUN;
        end
      end
      FLSC_LOCKUP_NMI: begin
        // NMI does not release this lockup.
        if (debugHalt) begin
          next_state = FLSC_RUN;
        end
      end
      FLSC_LOCKUP_HARD: begin
        // halt or NMI releases hard-fault lockup.
        if (debugHalt || nmiReq) begin
          next_state = FLSC_RUN;
        end
      end
      default: begin
        next_state = FLSC_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      state <= FLSC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Remembers where the last lockup arose.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      lastFaultLock <= 1'b0;
    end else if (lockEnter) begin
      lastFaultLock <= inNmiHandler;
    end
  end

  // arrival sets it; arrival wins over consumption.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      eventBit <= 1'b0;
    end else if (eventArrive && state != FLSC_SLEEP_EVENT) begin
      eventBit <= 1'b1;
    end else if (running && waitEventInstr && !faultNow && !lockEnter && !waitIrqInstr) begin
      eventBit <= 1'b0;
    end
  end

  // ==============================
  // Outputs.
  // ==============================
  logic nextSleeping;
  assign nextSleeping = (next_state == FLSC_SLEEP_IRQ) || (next_state == FLSC_SLEEP_EVENT);

  // lockup status follows the lockup states.
  // fetch stops while locked or sleeping.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      lockup <= 1'b0;
      fetchEnable <= 1'b0;
    end else begin
      lockup <= (next_state == FLSC_LOCKUP_NMI) || (next_state == FLSC_LOCKUP_HARD);
      fetchEnable <= (next_state == FLSC_RUN);
    end
  end

  // power-down select captured at deep-sleep entry.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      sleeping <= 1'b0;
      deepSleep <= 1'b0;
      standbyReq <= 1'b0;
    end else if (!nextSleeping) begin
      sleeping <= 1'b0;
      deepSleep <= 1'b0;
      standbyReq <= 1'b0;
    end else if (running) begin
      sleeping <= 1'b1;
      deepSleep <= ctrl[FLSC_CTRL_DEEP_SLEEP_SELECT];
      standbyReq <= ctrl[FLSC_CTRL_DEEP_SLEEP_SELECT] && ctrl[FLSC_CTRL_POWER_DOWN_SELECT];
    end
  end

  // handler waits while the global mask bit is set.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      excTakeAllowed <= 1'b0;
    end else begin
      excTakeAllowed <= (next_state == FLSC_RUN) && sufficient &&
                        !ctrl[FLSC_CTRL_GLOBAL_IRQ_MASK_BIT];
    end
  end

  // Read data, valid the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        FLSC_ADDR_CTRL: regRdata <= {27'h0, ctrl};
        FLSC_ADDR_STATUS: regRdata <= {25'h0, lastFaultLock, eventBit, state != FLSC_RUN,
                                       lockup, sleeping, deepSleep, standbyReq};
        FLSC_ADDR_FAULTS: regRdata <= {22'h0, faultSticky};
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule : flsc_fault_lockup_sleep_control

/* tb/flsc_properties.sv */
`timescale 1ns/100ps
// ==============================
// Temporal checks on the run-state controller ports.
// ==============================
module flsc_properties (
  input wire logic clk, // Core clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic [1:0] currentPrio, // Current level.
  input wire logic [1:0] svcPrio, // Call level.
  input wire logic svcExec, // Fault source.
  input wire logic bkptExec, // Fault source.
  input wire logic debugAttached, // Debugger present.
  input wire logic ldstBusErr, // Fault source.
  input wire logic vectorBusErr, // Fault source.
  input wire logic neverExecFetch, // Fault source.
  input wire logic fetchBusErr, // Fault source.
  input wire logic undefExec, // Fault source.
  input wire logic instrStateClear, // Fault source.
  input wire logic unalignedAccess, // Fault source.
  input wire logic protectionFault, // Fault source.
  input wire logic inNmiHandler, // Handler level.
  input wire logic inHardFaultHandler, // Handler level.
  input wire logic unstackPsrBusErr, // Unstack error.
  input wire logic debugHalt, // Halt request.
  input wire logic nmiReq, // NMI request.
  input wire logic excPending, // Pending exception.
  input wire logic [1:0] excPrio, // Its level.
  input wire logic waitIrqInstr, // Wait for interrupt.
  input wire logic hardFaultReq, // Output.
  input wire logic lockup, // Output.
  input wire logic fetchEnable, // Output.
  input wire logic sleeping, // Output.
  input wire logic deepSleep, // Output.
  input wire logic standbyReq, // Output.
  input wire logic excTakeAllowed // Output.
);
  logic anyFault;
  // fault sources
  // Any fault condition seen at the inputs in this cycle.
  assign anyFault = (svcExec && currentPrio <= svcPrio) || (bkptExec && !debugAttached) ||
    ldstBusErr || vectorBusErr || neverExecFetch || fetchBusErr || undefExec ||
    instrStateClear || unalignedAccess || protectionFault;
  // All checks share the core clock and its reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_fault_hard_req: assert property (anyFault && fetchEnable && !inNmiHandler
    && !inHardFaultHandler && !unstackPsrBusErr |=> hardFaultReq) else $error("fault lost");
  a_hard_has_cause: assert property (hardFaultReq |-> $past(anyFault && fetchEnable))
    else $error("hard fault without cause");
  a_hard_no_nest: assert property (anyFault && fetchEnable &&
    (inNmiHandler || inHardFaultHandler) |=> !hardFaultReq) else $error("nested hard fault");
  a_handler_locks: assert property (fetchEnable && (unstackPsrBusErr ||
    anyFault && (inNmiHandler || inHardFaultHandler)) |-> ##[1:2] lockup) else $error("no lock");
  a_lock_stalls: assert property (lockup |-> !fetchEnable && !sleeping)
    else $error("activity in lockup");
  a_lock_holds: assert property (lockup && !debugHalt && !nmiReq |=> lockup)
    else $error("lockup left without cause");
  a_halt_frees: assert property (lockup && debugHalt |-> ##[1:2] !lockup)
    else $error("halt kept lockup");
  a_wfi_sleeps: assert property (waitIrqInstr && fetchEnable && !anyFault
    && !unstackPsrBusErr && !debugHalt && !nmiReq |=> sleeping) else $error("no sleep");
  a_deep_sleeps: assert property (deepSleep |-> sleeping && !fetchEnable)
    else $error("deep sleep while awake");
  a_standby_deep: assert property (standbyReq |-> deepSleep)
    else $error("standby outside deep sleep");
  a_take_prio: assert property (excTakeAllowed |-> $past(excPending) &&
    $past(excPrio) < $past(currentPrio)) else $error("entry without priority");
  // Main scenarios reached.
  c_hard: cover property (hardFaultReq);
  c_unlock: cover property ($fell(lockup));
  c_wake: cover property ($fell(sleeping));
  c_standby: cover property (standbyReq);
endmodule : flsc_properties

bind flsc_fault_lockup_sleep_control flsc_properties u_props (.clk, .rst_b, .currentPrio,
  .svcPrio, .svcExec, .bkptExec, .debugAttached, .ldstBusErr, .vectorBusErr, .neverExecFetch,
  .fetchBusErr, .undefExec, .instrStateClear, .unalignedAccess, .protectionFault, .inNmiHandler,
  .inHardFaultHandler, .unstackPsrBusErr, .debugHalt, .nmiReq, .excPending, .excPrio,
  .waitIrqInstr, .hardFaultReq, .lockup, .fetchEnable, .sleeping, .deepSleep, .standbyReq,
  .excTakeAllowed);

/* tb/flsc_event_peer.sv */
`timescale 1ns/100ps
// ==============================
// Event sources beside the core: a peripheral pin and another processor.
// ==============================
module flsc_event_peer (
  input wire logic clk, // Core clock.
  input wire logic pinReq, // Raise a pin event.
  input wire logic sevReq, // Raise a send-event.
  output logic eventIn, // Event pin, low when unused.
  output logic sentEvent // Send-event pulse.
);
  // pin event
  // The pin rises off the clock edge and is sampled high at one edge only.
  initial begin
    eventIn = 1'b0;
    forever begin
      @(posedge pinReq);
      #3;
      eventIn = 1'b1;
      #10;
      eventIn = 1'b0;
    end
  end
  // processor event
  // The other processor signals its send-event as a one-cycle pulse.
  initial sentEvent = 1'b0;
  always @(posedge clk) begin
    sentEvent <= sevReq;
  end
endmodule : flsc_event_peer

/* tb/flsc_fault_lockup_sleep_control_tb_top.sv */
`timescale 1ns/100ps
// ==============================
// Self-checking bench for the run-state controller.
// ==============================
module flsc_fault_lockup_sleep_control_tb_top;
  import flsc_pkg::*;
  localparam int P_WFI = 10, P_WFE = 11, P_RET = 12, P_NEW = 13, P_UNSTK = 14, P_HALT = 15;
  localparam int P_PIN = 16, P_SEV = 17;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0, regRd = 1'b0;
  logic [1:0] currentPrio = 2'h0, svcPrio = 2'h0, excPrio = 2'h0;
  logic debugAttached = 1'b0, inNmiHandler = 1'b0, inHardFaultHandler = 1'b0;
  logic nmiReq = 1'b0, excPending = 1'b0;
  logic [17:0] pv = 18'h0; // Pulse inputs.
  logic eventIn, sentEvent, hardFaultReq, lockup, fetchEnable, sleeping, deepSleep;
  logic standbyReq, excTakeAllowed;
  logic [31:0] regRdata;
  int errors = 0, totalChecks = 0;
  // Core clock, 10 ns period.
  initial forever #5 clk = ~clk;
  flsc_fault_lockup_sleep_control dut_u (.clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd,
    .currentPrio, .svcPrio, .svcExec(pv[FLSC_F_SVC_PRIO]), .bkptExec(pv[FLSC_F_BREAKPOINT_INSTR]),
    .debugAttached, .ldstBusErr(pv[FLSC_F_LDST_BUS]), .vectorBusErr(pv[FLSC_F_VECTOR_BUS]),
    .neverExecFetch(pv[FLSC_F_NEVER_EXEC]), .fetchBusErr(pv[FLSC_F_FETCH_BUS]),
    .undefExec(pv[FLSC_F_UNDEF]), .instrStateClear(pv[FLSC_F_ISTATE]),
    .unalignedAccess(pv[FLSC_F_UNALIGNED]), .protectionFault(pv[FLSC_F_PROTECTION]),
    .inNmiHandler, .inHardFaultHandler, .unstackPsrBusErr(pv[P_UNSTK]), .debugHalt(pv[P_HALT]),
    .nmiReq, .excPending, .excPrio, .irqNewPending(pv[P_NEW]), .eventIn, .sentEvent,
    .waitIrqInstr(pv[P_WFI]), .waitEventInstr(pv[P_WFE]), .excReturnThread(pv[P_RET]),
    .regRdata, .hardFaultReq, .lockup, .fetchEnable, .sleeping, .deepSleep, .standbyReq,
    .excTakeAllowed);
  flsc_event_peer peer_u (.clk, .pinReq(pv[P_PIN]), .sevReq(pv[P_SEV]), .eventIn, .sentEvent);
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // Compares one settled output bit.
  task automatic chk(input string n, input logic e, input logic g);
    totalChecks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask : chk
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // One-cycle register read; masked data compared in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
    input string n);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    totalChecks++;
    if ((regRdata & m) !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, regRdata & m);
    end
  endtask : rd
  // One-cycle pulse on an input; returns once its effect has settled.
  task automatic pulse(input int i);
    @(posedge clk);
    pv[i] <= 1'b1;
    @(posedge clk);
    pv[i] <= 1'b0;
    #1;
  endtask : pulse
  // Bounded wait for a sleep and lockup combination.
  task automatic await(input logic s, input logic l, input string n);
    totalChecks++;
    for (int k = 0; k < 12; k++) begin
      if (sleeping === s && lockup === l) begin
        return;
      end
      @(posedge clk);
      #1;
    end
    errors++;
    $display("unexpected %s: expected %b%b, seen %b%b", n, s, l, sleeping, lockup);
    final_report;
  endtask : await
  // Reset values, read-back and an unmapped place.
  task automatic t_regs;
    rd(FLSC_ADDR_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
    rd(FLSC_ADDR_STATUS, 32'hFFFFFFFF, 32'h0, "status reset");
    wr(FLSC_ADDR_CTRL, 32'hFFFFFFFF);
    rd(FLSC_ADDR_CTRL, 32'hFFFFFFFF, 32'h1F, "ctrl rw");
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'hFFFFFFFF, 32'h0, "unmapped");
    wr(FLSC_ADDR_CTRL, 32'h0);
  endtask : t_regs
  // Every fault source, then a call and a breakpoint that are no faults.
  task automatic t_faults;
    @(posedge clk);
    currentPrio <= 2'h1;
    svcPrio <= 2'h1;
    for (int i = 0; i < FLSC_NUM_FAULTS; i++) begin
      pulse(i);
      chk("hard fault", 1'b1, hardFaultReq);
      rd(FLSC_ADDR_FAULTS, 32'h3FF, 32'h1 << i, "fault source");
      wr(FLSC_ADDR_FAULTS, 32'h1 << i);
    end
    @(posedge clk);
    currentPrio <= 2'h2;
    debugAttached <= 1'b1;
    pulse(FLSC_F_SVC_PRIO);
    chk("low prio call", 1'b0, hardFaultReq);
    pulse(FLSC_F_BREAKPOINT_INSTR);
    chk("attached breakpoint_instr", 1'b0, hardFaultReq);
  endtask : t_faults
  // Lockup born in the hard-fault handler, left by NMI.
  task automatic t_lock_hard;
    @(posedge clk);
    inHardFaultHandler <= 1'b1;
    pulse(FLSC_F_UNDEF);
    chk("no nested fault", 1'b0, hardFaultReq);
    await(1'b0, 1'b1, "hard lock");
    chk("locked fetch", 1'b0, fetchEnable);
    rd(FLSC_ADDR_STATUS, 32'h58, 32'h18, "hard lock status");
    @(posedge clk);
    nmiReq <= 1'b1;
    await(1'b0, 1'b0, "nmi unlock");
    @(posedge clk);
    nmiReq <= 1'b0;
    inHardFaultHandler <= 1'b0;
  endtask : t_lock_hard
  // Lockup born in the NMI handler ignores NMI; halt and unstack cases.
  task automatic t_lock_nmi;
    @(posedge clk);
    inNmiHandler <= 1'b1;
    pulse(FLSC_F_PROTECTION);
    await(1'b0, 1'b1, "nmi lock");
    rd(FLSC_ADDR_STATUS, 32'h58, 32'h58, "nmi lock status");
    @(posedge clk);
    nmiReq <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("nmi keeps lock", 1'b1, lockup);
    @(posedge clk);
    nmiReq <= 1'b0;
    inNmiHandler <= 1'b0;
    pulse(P_HALT);
    await(1'b0, 1'b0, "halt unlock");
    pulse(P_UNSTK);
    await(1'b0, 1'b1, "unstack lock");
    pulse(P_HALT);
    await(1'b0, 1'b0, "halt unlock 2");
  endtask : t_lock_nmi
  // Wait-for-interrupt in each sleep depth, woken only by enough priority.
  task automatic t_wfi;
    logic deep;
    logic pd;
    for (int k = 0; k < 3; k++) begin
      deep = (k > 0);
      pd = (k == 2);
      wr(FLSC_ADDR_CTRL, {30'h0, pd, deep});
      pulse(P_WFI);
      chk("wfi sleep", 1'b1, sleeping);
      chk("deep select", deep, deepSleep);
      chk("standby select", deep & pd, standbyReq);
      @(posedge clk);
      excPending <= 1'b1;
      excPrio <= 2'h2;
      repeat (4) @(posedge clk);
      #1;
      chk("equal prio sleeps", 1'b1, sleeping);
      @(posedge clk);
      excPrio <= 2'h0;
      await(1'b0, 1'b0, "wfi wake");
      chk("deep cleared", 1'b0, deepSleep);
      chk("entry allowed", 1'b1, excTakeAllowed);
      @(posedge clk);
      excPending <= 1'b0;
    end
  endtask : t_wfi
  // Global mask: wake without handler until the mask clears.
  task automatic t_mask;
    wr(FLSC_ADDR_CTRL, 32'h10);
    pulse(P_WFI);
    @(posedge clk);
    excPending <= 1'b1;
    await(1'b0, 1'b0, "masked wake");
    chk("masked entry", 1'b0, excTakeAllowed);
    wr(FLSC_ADDR_CTRL, 32'h0);
    @(posedge clk);
    #1;
    chk("unmasked entry", 1'b1, excTakeAllowed);
    @(posedge clk);
    excPending <= 1'b0;
  endtask : t_mask
  // Event register, event wakeups and event-on-pending.
  task automatic t_wfe;
    pulse(P_PIN);
    repeat (6) @(posedge clk);
    rd(FLSC_ADDR_STATUS, 32'h20, 32'h20, "event set");
    pulse(P_WFE);
    chk("event consumed", 1'b0, sleeping);
    rd(FLSC_ADDR_STATUS, 32'h20, 32'h0, "event cleared");
    pulse(P_WFE);
    chk("wfe sleep", 1'b1, sleeping);
    pulse(P_SEV);
    await(1'b0, 1'b0, "sev wake");
    pulse(P_WFE);
    pulse(P_PIN);
    await(1'b0, 1'b0, "pin wake");
    pulse(P_WFE);
    pulse(P_NEW);
    repeat (3) @(posedge clk);
    #1;
    chk("pending no wake", 1'b1, sleeping);
    wr(FLSC_ADDR_CTRL, 32'h8);
    pulse(P_NEW);
    await(1'b0, 1'b0, "pending wake");
    wr(FLSC_ADDR_CTRL, 32'h0);
  endtask : t_wfe
  // Sleep after a handler returns to thread, only when enabled.
  task automatic t_on_exit;
    pulse(P_RET);
    chk("return stays awake", 1'b0, sleeping);
    wr(FLSC_ADDR_CTRL, 32'h4);
    pulse(P_RET);
    chk("return sleeps", 1'b1, sleeping);
    @(posedge clk);
    excPending <= 1'b1;
    await(1'b0, 1'b0, "exit wake");
    @(posedge clk);
    excPending <= 1'b0;
  endtask : t_on_exit
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_faults;
    t_lock_hard;
    t_lock_nmi;
    t_wfi;
    t_mask;
    t_wfe;
    t_on_exit;
    final_report;
  end
endmodule : flsc_fault_lockup_sleep_control_tb_top
